// ==== src/irq_prio_pkg.sv ====
/*
  constants shared by the interrupt priority level block: special-function
  addresses, register masks, reset values, source order and bit positions.
  assumes an 8-bit special-function bus driven by the processor core.
*/
package irq_prio_pkg;

  // ----------------------------------------------------------------------
  // special-function addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_HIGH_BASE = 8'hb7;  // priority_high_base
  localparam logic [7:0] ADDR_LOW_BASE  = 8'hb8;  // priority_low_base, bit addressable
  localparam logic [7:0] ADDR_HIGH_EXT  = 8'hf7;  // priority_high_ext
  localparam logic [7:0] ADDR_LOW_EXT   = 8'hf8;  // priority_low_ext, bit addressable

  // ----------------------------------------------------------------------
  // defined bits and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] BASE_MASK  = 8'h7f;  // bits 6..0 defined
  localparam logic [7:0] EXT_MASK   = 8'h0f;  // bits 3..0 defined
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // sources, in fixed order within one level (index 0 served first)
  // ----------------------------------------------------------------------
  localparam int N_SRC = 11;
  localparam int N_EXT = 4;
  localparam logic [3:0] SRC_EXT_IRQ0      = 4'h0;
  localparam logic [3:0] SRC_TIMER0        = 4'h1;
  localparam logic [3:0] SRC_EXT_IRQ1      = 4'h2;
  localparam logic [3:0] SRC_TIMER1        = 4'h3;
  localparam logic [3:0] SRC_COUNTER_ARRAY = 4'h4;
  localparam logic [3:0] SRC_SERIAL_PORT   = 4'h5;
  localparam logic [3:0] SRC_TIMER2        = 4'h6;
  localparam logic [3:0] SRC_FIELDBUS      = 4'h7;  // first extended source
  localparam logic [3:0] SRC_CONVERTER     = 4'h8;
  localparam logic [3:0] SRC_OVERRUN       = 4'h9;
  localparam logic [3:0] SRC_SERIAL_PERIPH = 4'ha;

  // ----------------------------------------------------------------------
  // bit positions in the base registers
  // ----------------------------------------------------------------------
  localparam int BIT_EXT_IRQ0      = 0;
  localparam int BIT_TIMER0        = 1;
  localparam int BIT_EXT_IRQ1      = 2;
  localparam int BIT_TIMER1        = 3;
  localparam int BIT_SERIAL_PORT   = 4;
  localparam int BIT_TIMER2        = 5;
  localparam int BIT_COUNTER_ARRAY = 6;

  typedef logic [1:0] level_t;  // 00 lowest .. 11 highest

endpackage : irq_prio_pkg

// ==== src/level_arbiter.sv ====
/*
  combinational arbiter: picks the pending source of highest two-bit level,
  lowest index on a tie.
  assumes levels and requests are stable within the cycle; output is not
  registered, the instantiating module registers it.
*/
`timescale 1ns/100ps
module level_arbiter #(
  parameter int N = 11
) (
  input  wire logic [N-1:0]   req,    // pending enabled requests
  input  wire logic [2*N-1:0] levels, // level of source i at [2i+1:2i]
  output logic                found,  // some request pending
  output logic [3:0]          idx,    // winning source
  output logic [1:0]          lvl     // its level
);

  // ----------------------------------------------------------------------
  // scan upward; strict compare keeps the earliest of equal levels
  // ----------------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    lvl   = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || levels[2*i +: 2] > lvl)) begin
        found = 1'b1;
        idx   = 4'(i);
        lvl   = levels[2*i +: 2];
      end
    end
  end

endmodule : level_arbiter

// ==== src/interrupt_priority_levels.sv ====
/*
  priority level registers of the interrupt system and the arbitration that
  uses them: four 8-bit special-function registers, byte and bit writes,
  registered reads, and a registered choice of the request to serve.
  assumes the core presents already enabled pending requests and tells the
  block whether a routine is in service and at which level.
*/
// Contract
// - two bits per source, 00 lowest, 11 highest
// - serial peripheral level from bit 3 of ext pair
// - overrun level from bit 2 of ext pair
// - converter level from bit 1 of ext pair
// - fieldbus level from bit 0 of ext pair
// - classic sources take msb from base high register
// - reserved bits undefined on read, software writes zero
// - ext registers reset low nibble, low ext bit addressable
// - base high register resets bits 6..0 to zero
// - equal levels served in fixed source order
// - classic lsbs from base low register, same index
`timescale 1ns/100ps
module interrupt_priority_levels
  import irq_prio_pkg::*;
(
  input  wire logic                  clock,       // core clock
  input  wire logic                  nrst,        // synchronous, active low
  input  wire logic [7:0]            sfr_addr,    // special-function address
  input  wire logic                  sfr_wr,      // byte write strobe
  input  wire logic [7:0]            sfr_wdata,   // byte write data
  input  wire logic                  sfr_rd,      // byte read strobe
  input  wire logic                  bit_wr,      // bit write strobe
  input  wire logic [7:0]            bit_addr,    // bit address
  input  wire logic                  bit_val,     // bit value
  input  wire logic [N_SRC-1:0]      req,         // enabled pending requests
  input  wire logic                  svc_active,  // routine in service
  input  wire irq_prio_pkg::level_t  svc_level,   // its level
  output logic [7:0]                 sfr_rdata,   // read data
  output logic                       sfr_rvalid,  // read data valid pulse
  output logic                       irq_take,    // request chosen
  output logic [3:0]                 irq_src,     // chosen source
  output irq_prio_pkg::level_t       irq_lvl      // chosen level
);
  import irq_prio_pkg::*;

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [7:0] high_base_reg, high_base_next;   // priority_high_base
  logic [7:0] low_base_reg,  low_base_next;    // priority_low_base
  logic [7:0] high_ext_reg,  high_ext_next;    // priority_high_ext
  logic [7:0] low_ext_reg,   low_ext_next;     // priority_low_ext
  logic [7:0] rdata_reg,     rdata_next;       // registered read data
  logic       rvalid_reg,    rvalid_next;      // read answer pulse
  logic       take_reg,      take_next;        // arbitration result
  logic [3:0] src_reg,       src_next;
  level_t     lvl_reg,       lvl_next;

  // bit address hits register base when upper five bits match
  function automatic logic bit_hit(input logic [7:0] baddr, input logic [7:0] base);
    bit_hit = (baddr[7:3] == base[7:3]);
  endfunction : bit_hit

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // reserved bits are never stored, so a stray write of ones cannot stick
  always_comb begin
    high_base_next = high_base_reg;
    low_base_next  = low_base_reg;
    high_ext_next  = high_ext_reg;
    low_ext_next   = low_ext_reg;
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_HIGH_BASE: high_base_next = sfr_wdata & BASE_MASK;
        ADDR_LOW_BASE:  low_base_next  = sfr_wdata & BASE_MASK;
        ADDR_HIGH_EXT:  high_ext_next  = sfr_wdata & EXT_MASK;
        ADDR_LOW_EXT:   low_ext_next   = sfr_wdata & EXT_MASK;
        default:        ;                                        // not ours
      endcase
    end
    // single bit operations on the two bit addressable registers
    if (bit_wr && bit_hit(bit_addr, ADDR_LOW_EXT) && EXT_MASK[bit_addr[2:0]]) begin
      low_ext_next[bit_addr[2:0]] = bit_val;
    end
    if (bit_wr && bit_hit(bit_addr, ADDR_LOW_BASE) && BASE_MASK[bit_addr[2:0]]) begin
      low_base_next[bit_addr[2:0]] = bit_val;
    end
  end

  // ----------------------------------------------------------------------
  // reads: unmapped addresses answer zero, reserved bits read zero
  // ----------------------------------------------------------------------
  always_comb begin
    rvalid_next = sfr_rd;
    rdata_next  = rdata_reg;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_HIGH_BASE: rdata_next = high_base_reg;
        ADDR_LOW_BASE:  rdata_next = low_base_reg;
        ADDR_HIGH_EXT:  rdata_next = high_ext_reg;
        ADDR_LOW_EXT:   rdata_next = low_ext_reg;
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // level vector: two bits per source, msb from high, lsb from low
  // ----------------------------------------------------------------------
  logic [2*N_SRC-1:0] levels;  // level of source i at [2i+1:2i]

  // classic sources, msb and lsb at the same bit index
  always_comb begin
    levels = '0;
    levels[2*SRC_EXT_IRQ0 +: 2] =
      {high_base_reg[BIT_EXT_IRQ0], low_base_reg[BIT_EXT_IRQ0]};
    levels[2*SRC_TIMER0 +: 2] =
      {high_base_reg[BIT_TIMER0], low_base_reg[BIT_TIMER0]};
    levels[2*SRC_EXT_IRQ1 +: 2] =
      {high_base_reg[BIT_EXT_IRQ1], low_base_reg[BIT_EXT_IRQ1]};
    levels[2*SRC_TIMER1 +: 2] =
      {high_base_reg[BIT_TIMER1], low_base_reg[BIT_TIMER1]};
    levels[2*SRC_COUNTER_ARRAY +: 2] =
      {high_base_reg[BIT_COUNTER_ARRAY], low_base_reg[BIT_COUNTER_ARRAY]};
    levels[2*SRC_SERIAL_PORT +: 2] =
      {high_base_reg[BIT_SERIAL_PORT], low_base_reg[BIT_SERIAL_PORT]};
    levels[2*SRC_TIMER2 +: 2] =
      {high_base_reg[BIT_TIMER2], low_base_reg[BIT_TIMER2]};
    // extended sources: fieldbus bit 0 .. serial peripheral bit 3
    for (int k = 0; k < N_EXT; k++) begin
      levels[2*(int'(SRC_FIELDBUS)+k) +: 2] = {high_ext_reg[k], low_ext_reg[k]};
    end
  end

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  logic       arb_found;  // some request pending
  logic [3:0] arb_idx;    // winner, earliest on equal levels
  level_t     arb_lvl;    // winner level

  level_arbiter #(.N(N_SRC)) u_arb (
    .req    (req),
    .levels (levels),
    .found  (arb_found),
    .idx    (arb_idx),
    .lvl    (arb_lvl)
  );

  // a routine in service holds off anything not strictly above it
  always_comb begin
    take_next = arb_found && (!svc_active || arb_lvl > svc_level);
    src_next  = arb_found ? arb_idx : src_reg;
    lvl_next  = arb_found ? arb_lvl : lvl_reg;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      high_base_reg <= BASE_RESET;
      low_base_reg  <= BASE_RESET;
      high_ext_reg  <= EXT_RESET;
      low_ext_reg   <= EXT_RESET;
      rdata_reg     <= 8'h00;
      rvalid_reg    <= 1'b0;
      take_reg      <= 1'b0;
      src_reg       <= 4'h0;
      lvl_reg       <= 2'h0;
    end else begin
      high_base_reg <= high_base_next;
      low_base_reg  <= low_base_next;
      high_ext_reg  <= high_ext_next;
      low_ext_reg   <= low_ext_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
      take_reg      <= take_next;
      src_reg       <= src_next;
      lvl_reg       <= lvl_next;
    end
  end

  assign sfr_rdata  = rdata_reg;
  assign sfr_rvalid = rvalid_reg;
  assign irq_take   = take_reg;
  assign irq_src    = src_reg;
  assign irq_lvl    = lvl_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // a lone request with nothing in service
  sequence lone(int s);
    req == (N_SRC'(1) << s) && !svc_active;
  endsequence

  a_reset_base_clear: assert property (nrst && $past(!nrst) |-> high_base_reg == BASE_RESET)
    else $error("base high register not cleared by reset");
  a_reset_ext_clear: assert property (nrst && $past(!nrst) |-> (high_ext_reg | low_ext_reg) == 8'h00)
    else $error("extended registers not cleared by reset");
  a_reserved_reads_zero: assert property (sfr_rd && sfr_addr == ADDR_HIGH_EXT |=> sfr_rvalid && sfr_rdata[7:4] == 4'h0)
    else $error("reserved bits of extended register read nonzero");
  a_bit_write_lands: assert property (bit_wr && bit_addr[7:2] == ADDR_LOW_EXT[7:2] && !sfr_wr |=> low_ext_reg[$past(bit_addr[1:0])] == $past(bit_val))
    else $error("bit write to extended low register lost");
  a_spi_level_used: assert property (lone(SRC_SERIAL_PERIPH) |=> irq_take && irq_src == SRC_SERIAL_PERIPH && irq_lvl == $past({high_ext_reg[3], low_ext_reg[3]}))
    else $error("serial peripheral level not from bit 3");
  a_overrun_level_used: assert property (lone(SRC_OVERRUN) |=> irq_lvl == $past({high_ext_reg[2], low_ext_reg[2]}))
    else $error("overrun level not from bit 2");
  a_adc_level_used: assert property (lone(SRC_CONVERTER) |=> irq_lvl == $past({high_ext_reg[1], low_ext_reg[1]}))
    else $error("converter level not from bit 1");
  a_can_level_used: assert property (lone(SRC_FIELDBUS) |=> irq_lvl == $past({high_ext_reg[0], low_ext_reg[0]}))
    else $error("fieldbus level not from bit 0");
  a_pca_level_used: assert property (lone(SRC_COUNTER_ARRAY) |=> irq_lvl == $past({high_base_reg[6], low_base_reg[6]}))
    else $error("counter array level not from bit 6");
  a_highest_level_wins: assert property (req[SRC_EXT_IRQ0] && !svc_active |=> irq_take && irq_lvl >= $past(levels[1:0]))
    else $error("chosen level below a pending one");
  a_tie_fixed_order: assert property (req[SRC_EXT_IRQ0] && req[SRC_SERIAL_PERIPH] && levels[1:0] == 2'h3 && !svc_active |=> irq_src == SRC_EXT_IRQ0)
    else $error("tie not resolved in fixed order");
  a_no_equal_preempt: assert property (svc_active && svc_level == 2'h3 |=> !irq_take)
    else $error("preemption at equal level");

endmodule : interrupt_priority_levels

// ==== verification/core_model.sv ====
/*
  behavioural processor core seen from the priority block: it enters a
  service routine at the chosen level whenever the block takes a request.
  assumes the bench sets the routine length on dwell; inputs move 1 ns
  after the rising edge, like every bench driver.
*/
`timescale 1ns/100ps
module core_model
  import irq_prio_pkg::*;
(
  input  wire logic                  clock,       // core clock
  input  wire logic                  nrst,        // synchronous, active low
  input  wire logic                  irq_take,    // request chosen by the block
  input  wire irq_prio_pkg::level_t  irq_lvl,     // its level
  input  wire logic [7:0]            dwell,       // the routine lasts dwell + 1 cycles
  output logic                       svc_active,  // routine in service
  output irq_prio_pkg::level_t       svc_level    // its level
);
  import irq_prio_pkg::*;
  // ----------------------------------------------------------------------
  // service tracking
  // ----------------------------------------------------------------------
  logic [7:0] left;     // cycles still to run in the routine
  logic       rst_low;  // reset as sampled at the edge, like the block

  initial begin
    svc_active = 1'b0;
    svc_level  = 2'h0;
    left       = 8'h00;
  end

  // a nested take simply restarts the routine at the new level; no stack,
  // so return to the interrupted level is not modelled
  // reset is taken at the edge itself: the bench releases it 1 ns later,
  // and reading it after the delay would race with that release
  always @(posedge clock) begin
    rst_low = !nrst;
    #1;
    if (rst_low) begin
      svc_active = 1'b0;
      svc_level  = 2'h0;
      left       = 8'h00;
    end else if (irq_take === 1'b1) begin
      svc_active = 1'b1;
      svc_level  = irq_lvl;
      left       = dwell;
    end else if (left != 8'h00) begin
      left = left - 8'h01;
    end else begin
      svc_active = 1'b0;  // routine over, back to the main program
    end
  end
endmodule : core_model

// ==== verification/test_interrupt_priority_levels.sv ====
/*
  self-checking bench: random byte and bit writes, reads and requests,
  compared every cycle with a bench model of registers and arbitration.
  assumes the core model answers takes; reserved bits are written as zero.
*/
`timescale 1ns/100ps
module test_interrupt_priority_levels;
  import irq_prio_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clock, nrst, sfr_wr, sfr_rd, bit_wr, bit_val, svc_active, sfr_rvalid, irq_take;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, dwell;
  logic [N_SRC-1:0] req;
  logic [3:0] irq_src, e_src;
  level_t svc_level, irq_lvl, e_lvl;
  logic [7:0] hb, lb, he, le, e_rd;  // model registers and read data
  logic e_take, e_rv;
  int n_errors, samples_checked;
  logic [7:0] addrs [5] = '{8'hb7, 8'hb8, 8'hf7, 8'hf8, 8'h42};  // last one unmapped

  interrupt_priority_levels u_dut (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .bit_wr(bit_wr),
    .bit_addr(bit_addr), .bit_val(bit_val), .req(req), .svc_active(svc_active),
    .svc_level(svc_level), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .irq_take(irq_take), .irq_src(irq_src), .irq_lvl(irq_lvl));
  core_model u_core (.clock(clock), .nrst(nrst), .irq_take(irq_take), .irq_lvl(irq_lvl),
    .dwell(dwell), .svc_active(svc_active), .svc_level(svc_level));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // classic sources map to scattered bit positions, extended ones to 0..3
  function automatic level_t lvl_of(input int i);
    int p [7] = '{0, 1, 2, 3, 6, 4, 5};
    if (i < 7) return {hb[p[i]], lb[p[i]]};
    return {he[i-7], le[i-7]};
  endfunction : lvl_of

  // ----------------------------------------------------------------------
  // model: evaluated on the edge from pre-edge state, compared 5 ns later
  // ----------------------------------------------------------------------
  always @(posedge clock) begin : model
    int best;
    level_t bl;
    if (!nrst) begin
      {hb, lb, he, le, e_rd, e_src, e_lvl, e_take, e_rv} = '0;
    end else begin
      best = -1;
      bl = 2'h0;
      for (int i = 0; i < N_SRC; i++) begin
        if (req[i] && (best < 0 || lvl_of(i) > bl)) begin
          best = i;
          bl = lvl_of(i);
        end
      end
      e_take = (best >= 0) && (!svc_active || bl > svc_level);
      if (best >= 0) begin
        e_src = best[3:0];
        e_lvl = bl;
      end
      e_rv = sfr_rd;
      if (sfr_rd) begin
        case (sfr_addr)
          8'hb7: e_rd = hb;
          8'hb8: e_rd = lb;
          8'hf7: e_rd = he;
          8'hf8: e_rd = le;
          default: e_rd = 8'h00;
        endcase
      end
      if (sfr_wr) begin
        case (sfr_addr)
          8'hb7: hb = sfr_wdata & 8'h7f;
          8'hb8: lb = sfr_wdata & 8'h7f;
          8'hf7: he = sfr_wdata & 8'h0f;
          8'hf8: le = sfr_wdata & 8'h0f;
          default: ;
        endcase
      end
      // bit write lands after the byte write so it wins on its bit
      if (bit_wr && bit_addr[7:3] == 5'h17 && bit_addr[2:0] != 3'h7) lb[bit_addr[2:0]] = bit_val;
      if (bit_wr && bit_addr[7:3] == 5'h1f && bit_addr[2:0] < 3'h4) le[bit_addr[2:0]] = bit_val;
    end
    #5;
    check(8'(irq_take), 8'(e_take));
    check(8'(irq_src), 8'(e_src));
    check(8'(irq_lvl), 8'(e_lvl));
    check(8'(sfr_rvalid), 8'(e_rv));
    check(sfr_rdata, e_rd);
  end

  // ----------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------
  task automatic quiet;
    {sfr_wr, sfr_rd, bit_wr, bit_val, sfr_addr, sfr_wdata, bit_addr, req} = '0;
  endtask : quiet

  // back-to-back reads of every register and one unmapped address
  task automatic read_all;
    for (int i = 0; i < 5; i++) begin
      sfr_rd = 1'b1;
      sfr_addr = addrs[i];
      @(posedge clock);
      #1;
    end
    sfr_rd = 1'b0;
  endtask : read_all

  // software never sets reserved bits, so write data is masked first
  task automatic random_op;
    int op;
    op = $urandom_range(0, 3);
    sfr_addr = addrs[$urandom_range(0, 4)];
    sfr_wr = (op == 0 || op == 3);
    sfr_rd = (op == 1);
    bit_wr = (op >= 2);
    sfr_wdata = 8'($urandom) & (sfr_addr[6] ? 8'h0f : 8'h7f);
    bit_addr = $urandom_range(0, 1) ? 8'hf8 + 8'($urandom_range(0, 3))
                                    : 8'hb8 + 8'($urandom_range(0, 6));
    bit_val = 1'($urandom);
    req = ($urandom_range(0, 3) == 0) ? '0 : N_SRC'($urandom);
    dwell = 8'($urandom_range(0, 6));
  endtask : random_op

  initial begin
    n_errors = 0;
    samples_checked = 0;
    quiet();
    dwell = 8'h00;
    nrst = 1'b0;
    void'($urandom(84348));
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    read_all();
    repeat (3000) begin
      random_op();
      @(posedge clock);
      #1;
    end
    // every source alone with the core idle, over the random levels left above
    quiet();
    dwell = 8'h00;
    for (int i = 0; i < N_SRC; i++) begin
      repeat (8) @(posedge clock);
      #1 req = N_SRC'(1) << i;
      @(posedge clock);
      #1 req = '0;
    end
    @(posedge clock);
    #1;
    quiet();
    nrst = 1'b0;
    @(posedge clock);
    #1 nrst = 1'b1;
    read_all();
    repeat (3) @(posedge clock);
    print_verdict();
  end

  initial begin
    #(5000 * 100);
    n_errors++;
    print_verdict();
  end
endmodule : test_interrupt_priority_levels
